// [level_regs_pkg.sv]
package level_regs_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_AUDIO_INPUT_FULL_SCALE = 8'h13;
    localparam logic [7:0] OFF_AUDIO_MIN_OUTPUT_DRIVE = 8'h14;
    localparam logic [7:0] OFF_AUDIO_MAX_OUTPUT_DRIVE = 8'h15;
    localparam logic [7:0] OFF_MOTOR_NOMINAL_LEVEL = 8'h16;
    localparam logic [7:0] OFF_OVERDRIVE_LIMIT = 8'h17;
    localparam logic [7:0] OFF_CALIBRATION_LOSS_COMP = 8'h18;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_AUDIO_INPUT_FULL_SCALE = 8'hff;
    localparam logic [7:0] RST_AUDIO_MIN_OUTPUT_DRIVE = 8'h19;
    localparam logic [7:0] RST_AUDIO_MAX_OUTPUT_DRIVE = 8'hff;
    localparam logic [7:0] RST_MOTOR_NOMINAL_LEVEL = 8'h3e;
    localparam logic [7:0] RST_OVERDRIVE_LIMIT = 8'h8c;
    localparam logic [7:0] RST_CALIBRATION_LOSS_COMP = 8'h0c;

    // ------------------------------------------------------------
    // scaling
    // ------------------------------------------------------------
    localparam logic [7:0] FULL_SCALE_CODE = 8'hff;

endpackage : level_regs_pkg

// [level_scale_if.sv]
`timescale 1ns/10ps
interface level_scale_if;
    logic [7:0] level;
    logic [7:0] limit;
    logic [7:0] result;
    modport src (output level, output limit, input result);
    modport dst (input level, input limit, output result);
endinterface : level_scale_if

// [level_scaler.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------
// registered scale: result = level * limit / 255
// ------------------------------------------------------------
module level_scaler (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // operands and result
    level_scale_if.dst sc
);
    logic [15:0] prod;
    logic [7:0] quot;

    always_comb begin
        prod = 16'(sc.level) * 16'(sc.limit);
        quot = 8'(prod / 16'(level_regs_pkg::FULL_SCALE_CODE));
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sc.result <= 8'h00;
        end else begin
            sc.result <= quot;
        end
    end
endmodule : level_scaler

// [haptic_drive_level_registers.sv]
`timescale 1ns/10ps
// Functional notes
// - full-scale input reg sets input_trigger_pin peak level, value*1.8V/255.
// - input levels below the floor threshold are ignored by audio path.
// - minimum output drive is value/255 of full scale.
// - maximum output drive caps audio drive level handed to actuator drive engine.
// - closed loop uses nominal level register as full-scale reference.
// - calibration reads nominal level; host programs it beforehand.
// - open loop ignores nominal level and uses overdrive limit.
// - open loop uses overdrive limit as full-scale reference.
// - calibration completion stores loss compensation result.
// - playback gain multiplied by one plus compensation over 255.
module haptic_drive_level_registers (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // audio path
    input wire logic [7:0] audio_input_floor_i,
    input wire logic [7:0] audio_level_i,
    // drive control
    input wire logic closed_loop_i,
    input wire logic overdrive_active_i,
    input wire logic [7:0] drive_request_i,
    // calibration engine
    input wire logic cal_done_i,
    input wire logic [7:0] cal_comp_i,
    output logic [7:0] cal_nominal_level_o,
    // outputs to drive engine
    output logic [7:0] input_full_scale_o,
    output logic [7:0] audio_drive_o,
    output logic [7:0] full_scale_ref_o,
    output logic [8:0] comp_gain_o,
    output logic [7:0] drive_level_o
);
    logic [7:0] in_fs_reg;
    logic [7:0] min_drv_reg;
    logic [7:0] max_drv_reg;
    logic [7:0] nominal_reg;
    logic [7:0] od_limit_reg;
    logic [7:0] comp_reg;
    logic [7:0] rdata_next;
    logic [7:0] audio_drive_next;
    logic [7:0] ref_next;
    logic [7:0] drive_next;
    logic [7:0] audio_norm;
    logic [15:0] norm_prod;

    level_scale_if sc_if ();

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            in_fs_reg <= level_regs_pkg::RST_AUDIO_INPUT_FULL_SCALE;
            min_drv_reg <= level_regs_pkg::RST_AUDIO_MIN_OUTPUT_DRIVE;
            max_drv_reg <= level_regs_pkg::RST_AUDIO_MAX_OUTPUT_DRIVE;
            nominal_reg <= level_regs_pkg::RST_MOTOR_NOMINAL_LEVEL;
            od_limit_reg <= level_regs_pkg::RST_OVERDRIVE_LIMIT;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                level_regs_pkg::OFF_AUDIO_INPUT_FULL_SCALE: begin
                    in_fs_reg <= reg_wdata_i;
                end
                level_regs_pkg::OFF_AUDIO_MIN_OUTPUT_DRIVE: begin
                    min_drv_reg <= reg_wdata_i;
                end
                level_regs_pkg::OFF_AUDIO_MAX_OUTPUT_DRIVE: begin
                    max_drv_reg <= reg_wdata_i;
                end
                level_regs_pkg::OFF_MOTOR_NOMINAL_LEVEL: begin
                    nominal_reg <= reg_wdata_i;
                end
                level_regs_pkg::OFF_OVERDRIVE_LIMIT: begin
                    od_limit_reg <= reg_wdata_i;
                end
                default: begin
                end
            endcase
        end
    end

    // calibration store wins over a same-cycle host write
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            comp_reg <= level_regs_pkg::RST_CALIBRATION_LOSS_COMP;
        end else if (cal_done_i) begin
            comp_reg <= cal_comp_i;
        end else if (reg_wr_i &&
                     reg_addr_i == level_regs_pkg::OFF_CALIBRATION_LOSS_COMP) begin
            comp_reg <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // read back
    // ------------------------------------------------------------
    always_comb begin
        case (reg_addr_i)
            level_regs_pkg::OFF_AUDIO_INPUT_FULL_SCALE: rdata_next = in_fs_reg;
            level_regs_pkg::OFF_AUDIO_MIN_OUTPUT_DRIVE: rdata_next = min_drv_reg;
            level_regs_pkg::OFF_AUDIO_MAX_OUTPUT_DRIVE: rdata_next = max_drv_reg;
            level_regs_pkg::OFF_MOTOR_NOMINAL_LEVEL: rdata_next = nominal_reg;
            level_regs_pkg::OFF_OVERDRIVE_LIMIT: rdata_next = od_limit_reg;
            level_regs_pkg::OFF_CALIBRATION_LOSS_COMP: rdata_next = comp_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // audio path: floor, normalise to full scale, min/max drive
    // ------------------------------------------------------------
    always_comb begin
        norm_prod = 16'(audio_level_i) * 16'(level_regs_pkg::FULL_SCALE_CODE);
        if (audio_level_i >= in_fs_reg || in_fs_reg == 8'h00) begin
            audio_norm = level_regs_pkg::FULL_SCALE_CODE;
        end else begin
            audio_norm = 8'(norm_prod / 16'(in_fs_reg));
        end
        if (audio_level_i < audio_input_floor_i) begin
            audio_drive_next = 8'h00;
        end else if (audio_norm > max_drv_reg ||
                     min_drv_reg > max_drv_reg) begin
            audio_drive_next = max_drv_reg;
        end else if (audio_norm < min_drv_reg) begin
            audio_drive_next = min_drv_reg;
        end else begin
            audio_drive_next = audio_norm;
        end
    end

    // ------------------------------------------------------------
    // full-scale reference and drive level
    // ------------------------------------------------------------
    always_comb begin
        if (closed_loop_i) begin
            ref_next = nominal_reg;
        end else begin
            ref_next = od_limit_reg;
        end
        if (closed_loop_i && overdrive_active_i) begin
            drive_next = od_limit_reg;
        end else begin
            drive_next = sc_if.result;
        end
    end

    assign sc_if.level = drive_request_i;
    assign sc_if.limit = ref_next;

    level_scaler u_scaler (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .sc(sc_if.dst)
    );

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            audio_drive_o <= 8'h00;
            full_scale_ref_o <= level_regs_pkg::RST_OVERDRIVE_LIMIT;
            input_full_scale_o <= level_regs_pkg::RST_AUDIO_INPUT_FULL_SCALE;
            cal_nominal_level_o <= level_regs_pkg::RST_MOTOR_NOMINAL_LEVEL;
            comp_gain_o <= 9'h100;
            drive_level_o <= 8'h00;
        end else begin
            audio_drive_o <= audio_drive_next;
            full_scale_ref_o <= ref_next;
            input_full_scale_o <= in_fs_reg;
            cal_nominal_level_o <= nominal_reg;
            comp_gain_o <= 9'h0ff + {1'b0, comp_reg};
            drive_level_o <= drive_next;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    floor_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        audio_level_i < audio_input_floor_i |=> audio_drive_o == 8'h00)
        else $error("audio below floor not ignored");
    max_cap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        audio_level_i >= audio_input_floor_i |=> audio_drive_o <= $past(max_drv_reg))
        else $error("audio drive above max");
    min_drive_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        audio_level_i >= audio_input_floor_i && min_drv_reg <= max_drv_reg
        |=> audio_drive_o >= $past(min_drv_reg))
        else $error("audio drive below min");
    closed_ref_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        closed_loop_i |=> full_scale_ref_o == $past(nominal_reg))
        else $error("closed loop reference wrong");
    open_ref_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !closed_loop_i |=> full_scale_ref_o == $past(od_limit_reg))
        else $error("open loop reference wrong");
    overdrive_clamp_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        closed_loop_i && overdrive_active_i |=> drive_level_o == $past(od_limit_reg))
        else $error("overdrive not clamped");
    cal_store_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        cal_done_i ##1 !reg_wr_i ##0 reg_addr_i == level_regs_pkg::OFF_CALIBRATION_LOSS_COMP
        |=> reg_rdata_o == $past(cal_comp_i, 2))
        else $error("calibration result not stored");
    write_back_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        reg_wr_i && reg_addr_i == level_regs_pkg::OFF_MOTOR_NOMINAL_LEVEL
        ##1 !reg_wr_i ##0 reg_addr_i == level_regs_pkg::OFF_MOTOR_NOMINAL_LEVEL
        |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("nominal level readback wrong");
    comp_gain_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        ##1 1'b1 |=> comp_gain_o == 9'h0ff + {1'b0, $past(comp_reg)})
        else $error("compensation gain wrong");
    full_scale_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        audio_level_i >= in_fs_reg && audio_level_i >= audio_input_floor_i
        |=> audio_drive_o == $past(max_drv_reg))
        else $error("full scale input not full drive");

    cal_seen_c: cover property (@(posedge sys_clk_i) disable iff (rst_i) cal_done_i);
    od_seen_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        closed_loop_i && overdrive_active_i);
    floor_seen_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        audio_level_i < audio_input_floor_i);
    cal_wr_race_c: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        cal_done_i && reg_wr_i);
endmodule : haptic_drive_level_registers

// [cal_engine_model.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------
// calibration engine stand-in: answers a start after a delay
// ------------------------------------------------------------
module cal_engine_model #(
    parameter int DELAY = 4
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // request and result
    input wire logic start_i,
    input wire logic [7:0] nominal_i,
    output logic done_o,
    output logic [7:0] comp_o
);
    int cnt;
    always_ff @(posedge sys_clk_i) begin
        done_o <= 1'b0;
        comp_o <= ~comp_o;
        if (rst_i) begin
            cnt <= 0;
            comp_o <= 8'h00;
        end else if (start_i) begin
            cnt <= DELAY;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                done_o <= 1'b1;
                comp_o <= nominal_i ^ 8'h5a;
            end
        end
    end
endmodule : cal_engine_model

// [haptic_drive_level_registers_test.sv]
`timescale 1ns/10ps
module haptic_drive_level_registers_test;
    logic sys_clk_i = 0, rst_i = 1, reg_wr_i = 0, closed_loop_i = 0;
    logic overdrive_active_i = 0, cal_done, cal_start = 0;
    logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, cal_comp;
    logic [7:0] floor_v = 0, level_v = 0, request_v = 0, nominal, in_fs;
    logic [7:0] aud_drv, fs_ref, drv_lvl;
    logic [8:0] comp_gain;
    logic [7:0] mem [8'h13:8'h18] = '{8'hff, 8'h19, 8'hff, 8'h3e, 8'h8c, 8'h0c};
    int seed = 32'h74dd, miscompares = 0, n_tests = 0, k, a, t;

    always #5 sys_clk_i = ~sys_clk_i;

    haptic_drive_level_registers i_haptic_drive_level_registers (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .audio_input_floor_i(floor_v),
        .audio_level_i(level_v), .closed_loop_i(closed_loop_i),
        .overdrive_active_i(overdrive_active_i),
        .drive_request_i(request_v), .cal_done_i(cal_done),
        .cal_comp_i(cal_comp), .cal_nominal_level_o(nominal),
        .input_full_scale_o(in_fs), .audio_drive_o(aud_drv),
        .full_scale_ref_o(fs_ref), .comp_gain_o(comp_gain),
        .drive_level_o(drv_lvl));

    cal_engine_model i_cal_engine_model (.sys_clk_i(sys_clk_i),
        .rst_i(rst_i), .start_i(cal_start), .nominal_i(nominal),
        .done_o(cal_done), .comp_o(cal_comp));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] r8();
        r8 = 8'($random(seed));
    endfunction : r8

    function automatic logic [7:0] aud_exp(int fl, int lv);
        int n;
        if (lv < fl) return 8'h00;
        n = lv * 255 / mem[8'h13];
        if (n < mem[8'h14]) n = mem[8'h14];
        if (n > mem[8'h15]) n = mem[8'h15];
        return 8'(n);
    endfunction : aud_exp

    task automatic tick();
        @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input int ad, input logic [7:0] d);
        reg_wr_i = 1'b1;
        reg_addr_i = 8'(ad);
        reg_wdata_i = d;
        tick();
        if (ad >= 'h13 && ad <= 'h18) mem[ad] = d;
    endtask : wr

    task automatic rd_all();
        reg_wr_i = 1'b0;
        for (a = 'h12; a <= 'h19; a++) begin
            reg_addr_i = 8'(a);
            tick();
            chk(reg_rdata_o, (a < 'h13 || a > 'h18) ? 8'h00 : mem[a]);
        end
    endtask : rd_all

    task automatic complete_run();
        $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk_i);
        #1 rst_i = 1'b0;
        rd_all();
        chk(fs_ref, 8'h8c);
        chk(comp_gain, 9'h10b);
        for (k = 0; k < 3; k++) begin
            for (a = 'h12; a <= 'h19; a++) wr(a, r8());
            rd_all();
            chk(in_fs, mem[8'h13]);
            chk(nominal, mem[8'h16]);
            chk(comp_gain, 9'd255 + mem[8'h18]);
        end
        for (k = 0; k < 16; k++) begin
            closed_loop_i = k[0];
            overdrive_active_i = k[1];
            request_v = (k == 3) ? 8'hff : r8();
            tick();
            tick();
            chk(fs_ref, k[0] ? mem[8'h16] : mem[8'h17]);
            chk(drv_lvl, (k[0] && k[1]) ? mem[8'h17] : 8'(request_v
                * (k[0] ? mem[8'h16] : mem[8'h17]) / 255));
        end
        for (k = 0; k < 8; k++) begin
            wr('h13, r8() | 8'h80);
            wr('h14, r8() & 8'h7f);
            wr('h15, r8() | 8'h80);
            reg_wr_i = 1'b0;
            floor_v = r8();
            level_v = 8'($unsigned(r8()) % (mem[8'h13] + 1));
            tick();
            chk(aud_drv, aud_exp(floor_v, level_v));
        end
        // nominal level changed, so calibration is run again each time
        for (k = 0; k < 2; k++) begin
            wr('h16, r8());
            reg_wr_i = 1'b0;
            cal_start = 1'b1;
            tick();
            cal_start = 1'b0;
            reg_addr_i = 8'h18;
            for (t = 0; t < 50 && cal_done !== 1'b1; t++) tick();
            if (t == 50) begin
                miscompares++;
                complete_run();
            end
            if (k == 0) begin
                wr('h18, 8'h00);
            end else begin
                tick();
                tick();
            end
            mem[8'h18] = mem[8'h16] ^ 8'h5a;
            if (k != 0) chk(reg_rdata_o, mem[8'h18]);
            rd_all();
            chk(comp_gain, 9'd255 + mem[8'h18]);
        end
        complete_run();
    end
endmodule : haptic_drive_level_registers_test
